// ==== logic/dpc_params.svh ====
// Purpose: timing and layout constants for the dual-port memory controller
// Assumes: 250 MHz clock (4 ns period), slowest speed grade timings
// Notes:   times in ns; cycle counts derived and rounded up
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

`define DPC_CLK_PERIOD_NS            4
`define DPC_SELECT_ACCESS_TIME_NS    25
`define DPC_OE_ACCESS_TIME_NS        13
`define DPC_WRITE_DATA_SETUP_NS      15
`define DPC_CROSS_PORT_FLOW_NS       35
`define DPC_BUSY_FROM_MATCH_NS       20
`define DPC_BUSY_FROM_SELECT_NS      20
`define DPC_TOKEN_OP_GAP_NS          12
`define DPC_TOKEN_WR_TO_RD_NS        12
`define DPC_CYC(ns) (((ns) + `DPC_CLK_PERIOD_NS - 1) / `DPC_CLK_PERIOD_NS)
`define DPC_MAILBOX_LEFT_OFS         1
`define DPC_TOKEN_BIT                0

`endif

// ==== logic/dpc_pkg.sv ====
// Purpose: types shared by the dual-port memory controller
// Assumes: x16 organisation by default
// Notes:   request/answer groups travel as packed structs
package dpc_pkg;
  typedef enum logic [1:0] {
    DPC_OP_READ  = 2'h0,
    DPC_OP_WRITE = 2'h1
  } dpc_op_t;

  typedef struct packed {
    dpc_op_t      op;
    logic         token;
    logic         hi_en;
    logic         lo_en;
    logic [15:0]  addr;
    logic [17:0]  data;
  } dpc_req_t;

  typedef struct packed {
    logic [17:0]  data;
    logic         token_won;
    logic         busy_seen;
  } dpc_rsp_t;

  typedef enum logic [2:0] {
    DPC_IDLE   = 3'h0,
    DPC_SETTLE = 3'h1,
    DPC_ACCESS = 3'h3,
    DPC_GAP    = 3'h4,
    DPC_DONE   = 3'h2
  } dpc_state_t;
endpackage

// ==== logic/dpc_host.sv ====
// Purpose: host controller driving one port of an asynchronous dual-port
//          memory with mailbox interrupt and token latches
// Assumes: one clk_in domain; pin inputs synchronised by two flops
// Notes:   one access at a time; req_ready_out low while busy
//
// Behaviour
// - wait flow-through delay after opposite write
// - read asserts select and output enable together
// - wait busy settle before slave write
// - token select with chip select high
// - gap with select off before readback
`timescale 1ns/1ps
`default_nettype none
`include "dpc_params.svh"

module dpc_host #(
  parameter int AW = 15,
  parameter int DW = 16
) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire dpc_pkg::dpc_req_t req_in,
  input  wire logic            req_valid_in,
  output logic                 req_ready_out,
  output dpc_pkg::dpc_rsp_t    rsp_out,
  output logic                 rsp_valid_out,
  output logic                 irq_out,
  output logic                 chip_select_n_out,
  output logic                 token_latch_select_n_out,
  output logic                 write_n_out,
  output logic                 output_enable_n_out,
  output logic                 high_byte_select_n_out,
  output logic                 low_byte_select_n_out,
  output logic [15:0]          addr_out,
  output logic [17:0]          data_out,
  output logic                 data_oe_out,
  input  wire logic [17:0]     data_in,
  input  wire logic            busy_n_in,
  input  wire logic            mailbox_int_n_in
);
  import dpc_pkg::*;

  localparam int RD_CYC = `DPC_CYC(`DPC_SELECT_ACCESS_TIME_NS) + 2;
  localparam int WR_CYC = `DPC_CYC(`DPC_WRITE_DATA_SETUP_NS);
  localparam int BUSY_CYC = `DPC_CYC(`DPC_BUSY_FROM_SELECT_NS) + 2;
  localparam int FLOW_CYC = `DPC_CYC(`DPC_CROSS_PORT_FLOW_NS);
  localparam int GAP_CYC = `DPC_CYC(`DPC_TOKEN_OP_GAP_NS);
  localparam int TOK_CYC = `DPC_CYC(`DPC_TOKEN_WR_TO_RD_NS);

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic [17:0] data_s1;
  logic [17:0] data_s2;
  logic [1:0]  busy_s;
  logic [1:0]  int_s;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_s1 <= 18'h0;
      data_s2 <= 18'h0;
      busy_s  <= 2'h3;
      int_s   <= 2'h3;
    end else begin
      data_s1 <= data_in;
      data_s2 <= data_s1;
      busy_s  <= {busy_s[0], busy_n_in};
      int_s   <= {int_s[0], mailbox_int_n_in};
    end
  end
  wire busy_now = ~busy_s[1];

  // ---------------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------------
  dpc_state_t state;
  dpc_state_t next_state;
  dpc_req_t   cur;
  dpc_req_t   next_cur;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       saw_busy;
  logic       next_saw_busy;
  logic       last_tok_wr;
  logic       next_last_tok_wr;
  dpc_rsp_t   next_rsp;
  logic       next_rsp_valid;

  wire is_wr = (cur.op == DPC_OP_WRITE);

  always_comb begin
    next_state       = state;
    next_cur         = cur;
    next_cnt         = cnt;
    next_saw_busy    = saw_busy;
    next_last_tok_wr = last_tok_wr;
    next_rsp         = rsp_out;
    next_rsp_valid   = 1'b0;
    case (state)
      DPC_IDLE: begin
        if (req_valid_in) begin
          next_cur      = req_in;
          next_cnt      = 8'(BUSY_CYC);
          next_saw_busy = 1'b0;
          // readback of a token needs the select-off gap first
          if (req_in.token && req_in.op == DPC_OP_READ && last_tok_wr) begin
            next_state = DPC_GAP;
            next_cnt   = 8'(GAP_CYC > TOK_CYC ? GAP_CYC : TOK_CYC);
          end else begin
            next_state = DPC_SETTLE;
          end
        end
      end
      DPC_GAP: begin
        if (cnt == 8'h0) begin
          next_state = DPC_SETTLE;
          next_cnt   = 8'(BUSY_CYC);
        end else begin
          next_cnt = cnt - 8'h1;
        end
      end
      DPC_SETTLE: begin
        // strobes held off until busy has settled
        if (busy_now) begin
          next_saw_busy = 1'b1;
          next_cnt      = 8'(BUSY_CYC);
        end else if (cnt == 8'h0) begin
          next_state = DPC_ACCESS;
          next_cnt   = 8'(is_wr ? WR_CYC : RD_CYC);
          // a read that may race a remote write waits flow-through
          if (!is_wr && saw_busy) next_cnt = 8'(RD_CYC + FLOW_CYC);
        end else begin
          next_cnt = cnt - 8'h1;
        end
      end
      DPC_ACCESS: begin
        if (busy_now) next_saw_busy = 1'b1;
        if (cnt == 8'h0) begin
          next_state = DPC_DONE;
          next_rsp.busy_seen = saw_busy | busy_now;
          // token value shows on every line; bit 0 low means ours
          next_rsp.token_won = cur.token & ~data_s2[`DPC_TOKEN_BIT];
          next_rsp.data      = is_wr ? 18'h0 : data_s2;
          next_rsp_valid     = 1'b1;
          next_last_tok_wr   = cur.token & is_wr;
        end else begin
          next_cnt = cnt - 8'h1;
        end
      end
      DPC_DONE: begin
        next_state = DPC_IDLE;
      end
      default: next_state = DPC_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state         <= DPC_IDLE;
      cur           <= '0;
      cnt           <= 8'h0;
      saw_busy      <= 1'b0;
      last_tok_wr   <= 1'b0;
      rsp_out       <= '0;
      rsp_valid_out <= 1'b0;
    end else begin
      state         <= next_state;
      cur           <= next_cur;
      cnt           <= next_cnt;
      saw_busy      <= next_saw_busy;
      last_tok_wr   <= next_last_tok_wr;
      rsp_out       <= next_rsp;
      rsp_valid_out <= next_rsp_valid;
    end
  end

  // ---------------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------------
  // strobes come from state flops; DONE releases them so the write
  // terminates on the select rise with data still held
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chip_select_n_out        <= 1'b1;
      token_latch_select_n_out <= 1'b1;
      write_n_out              <= 1'b1;
      output_enable_n_out      <= 1'b1;
      high_byte_select_n_out   <= 1'b1;
      low_byte_select_n_out    <= 1'b1;
      addr_out                 <= 16'h0;
      data_out                 <= 18'h0;
      data_oe_out              <= 1'b0;
    end else begin
      // token access keeps chip select high
      chip_select_n_out <= ~((next_state == DPC_ACCESS) & ~next_cur.token);
      token_latch_select_n_out <=
        ~((next_state == DPC_ACCESS) & next_cur.token);
      write_n_out <= ~((next_state == DPC_ACCESS) &
                       (next_cur.op == DPC_OP_WRITE));
      // read drives select and output enable together
      output_enable_n_out <= ~((next_state == DPC_ACCESS) &
                               (next_cur.op == DPC_OP_READ));
      // byte lanes
      high_byte_select_n_out <= ~((next_state == DPC_ACCESS) &
                                  (next_cur.hi_en | next_cur.token));
      low_byte_select_n_out  <= ~((next_state == DPC_ACCESS) &
                                  (next_cur.lo_en | next_cur.token));
      // token access keeps address bits 2:0 only; a token write keeps data bit 0 only
      addr_out <= next_cur.token ? {13'h0, next_cur.addr[2:0]}
                                 : (next_cur.addr & 16'((1 << AW) - 1));
      data_out <= next_cur.token ? {17'h0, next_cur.data[0]}
                                 : (next_cur.data & 18'((1 << DW) - 1));
      data_oe_out <= (next_state == DPC_ACCESS || next_state == DPC_DONE) &
                     (next_cur.op == DPC_OP_WRITE);
    end
  end

  assign req_ready_out = (state == DPC_IDLE);
  // mailbox interrupt from the device, level
  assign irq_out = ~int_s[1];
endmodule

`default_nettype wire

// ==== bench/dpc_dev_model.sv ====
// Purpose: left port of the shared memory, tokens and mailbox
// Assumes: x16 lanes, pins move only on host clock edges
// Notes:   the other port acts only through the tasks
`timescale 1ns/1ps
`default_nettype none
module dpc_dev_model (
  input  wire logic        cs_n_in,
  input  wire logic        tk_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        hb_n_in,
  input  wire logic        lb_n_in,
  input  wire logic [15:0] a_in,
  input  wire logic [17:0] d_in,
  input  wire logic        d_oe_in,
  output logic      [17:0] q_out,
  output logic             busy_n_out,
  output logic             int_n_out
);
  logic [15:0] mem [int];
  logic [7:0]  mine = '0, theirs = '0, hwant = '0;
  logic [17:0] hold = '0, last = '0;
  logic        oint = 0;
  logic [2:0]  k;
  logic [15:0] m;
  // delayed copy: strobes and lanes rise together at the end
  // undriven bus reads inverted, so an early data release is caught
  wire [15:0] dv = d_oe_in ? d_in[15:0] : ~d_in[15:0];
  wire [34:0] #1 pd = {tk_n_in, hb_n_in, lb_n_in, a_in, dv};
  wire rd_on = !oe_n_in && we_n_in && !(cs_n_in && tk_n_in);
  wire wr_on = !we_n_in && !(cs_n_in && tk_n_in);
  initial begin
    busy_n_out = 1;
    int_n_out = 1;
  end
  // released bus shows the inverse, never a stale match
  assign q_out = rd_on ? hold : ~last;
  always @(posedge rd_on)
    hold = !tk_n_in ? {18{!mine[a_in[2:0]]}}
         : {2'h0, mem.exists(a_in) ? mem[a_in] : 16'h0};
  always @(negedge rd_on) begin
    last = hold;
    if (pd[34] && pd[31:16] == 16'h7ffe && busy_n_out)
      int_n_out = 1;
  end
  always @(negedge wr_on) begin
    k = pd[18:16];
    if (!pd[34]) begin
      hwant[k] = !pd[0] && theirs[k];
      mine[k] = !pd[0] && !theirs[k];
    end else if (busy_n_out) begin
      m = mem.exists(pd[31:16]) ? mem[pd[31:16]] : 16'h0;
      if (!pd[33]) m[15:8] = pd[15:8];
      if (!pd[32]) m[7:0] = pd[7:0];
      mem[pd[31:16]] = m;
      if (pd[31:16] == 16'h7fff) oint = 1;
    end
  end
  task mail(); int_n_out = 0; endtask
  task busy(input logic b); busy_n_out = b; endtask
  task grab(input int i); theirs[i] = !mine[i]; endtask
  task drop(input int i);
    theirs[i] = 0;
    mine[i] = hwant[i];
    hwant[i] = 0;
  endtask
endmodule
`default_nettype wire

// ==== bench/dpc_host_props.sv ====
// Purpose: port checks on the memory host controller
// Assumes: one clock, reset high
// Notes:   bound into every host instance
`timescale 1ns/1ps
`default_nettype none
module dpc_host_props (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        req_valid_in,
  input wire logic        req_ready_out,
  input wire logic        rsp_valid_out,
  input wire logic        chip_select_n_out,
  input wire logic        token_latch_select_n_out,
  input wire logic        write_n_out,
  input wire logic        output_enable_n_out,
  input wire logic        data_oe_out,
  input wire logic [15:0] addr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire cs = !chip_select_n_out;
  wire tk = !token_latch_select_n_out;
  sel_excl_a: assert property (!(cs && tk))
    else $error("selects overlap");
  read_drive_a:
    assert property (!output_enable_n_out |-> write_n_out && !data_oe_out)
    else $error("drive during read");
  write_drive_a: assert property (!write_n_out |-> data_oe_out)
    else $error("write without data");
  data_hold_a: assert property ($rose(write_n_out) |-> data_oe_out)
    else $error("data released at write end");
  settle_gap_a:
    assert property (req_valid_in && req_ready_out |=> (!cs && !tk) [*8])
    else $error("strobe before settle");
  rsp_end_a: assert property (rsp_valid_out |-> $rose(!cs && !tk))
    else $error("answer not at strobe end");
  ready_idle_a: assert property (cs || tk |-> !req_ready_out)
    else $error("ready during access");
  token_gap_a:
    assert property ($rose(!tk) && !$past(write_n_out)
                     |-> (!tk || output_enable_n_out) [*3])
    else $error("token readback too soon");
  addr_hold_a: assert property (cs && $past(cs) |-> $stable(addr_out))
    else $error("address moved in access");
endmodule
bind dpc_host dpc_host_props props_u (.clk_in, .rst_in, .req_valid_in,
  .req_ready_out, .rsp_valid_out, .chip_select_n_out,
  .token_latch_select_n_out, .write_n_out, .output_enable_n_out,
  .data_oe_out, .addr_out);
`default_nettype wire

// ==== bench/test_dpc_host.sv ====
// Purpose: self-checking bench for the memory host controller
// Assumes: device model on the far side, x16 lanes
// Notes:   fixed-seed random data plus corner addresses
`timescale 1ns/1ps
`default_nettype none
module test_dpc_host;
  import dpc_pkg::*;
  logic      clk_in = 0;
  logic      rst_in = 1;
  logic      vld = 0;
  dpc_req_t  req = '0;
  dpc_rsp_t  rsp;
  wire logic rdy, rv, irq, cs_n, tk_n, we_n, oe_n, hb_n, lb_n, bsy_n, int_n;
  wire logic doe;
  wire logic [15:0] a;
  wire logic [17:0] dq, dout;
  int        bad_count = 0;
  int        compares = 0;
  always #2 clk_in = ~clk_in;
  dpc_host #(.AW(15), .DW(16)) dut_u (.clk_in, .rst_in, .req_in(req),
    .req_valid_in(vld), .req_ready_out(rdy), .rsp_out(rsp),
    .rsp_valid_out(rv), .irq_out(irq), .chip_select_n_out(cs_n),
    .token_latch_select_n_out(tk_n), .write_n_out(we_n),
    .output_enable_n_out(oe_n), .high_byte_select_n_out(hb_n),
    .low_byte_select_n_out(lb_n), .addr_out(a), .data_out(dout),
    .data_oe_out(doe), .data_in(dq), .busy_n_in(bsy_n),
    .mailbox_int_n_in(int_n));
  dpc_dev_model dev_u (.cs_n_in(cs_n), .tk_n_in(tk_n), .we_n_in(we_n),
    .oe_n_in(oe_n), .hb_n_in(hb_n), .lb_n_in(lb_n), .a_in(a), .d_in(dout),
    .d_oe_in(doe), .q_out(dq), .busy_n_out(bsy_n), .int_n_out(int_n));
  task automatic report_and_stop;
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [17:0] merge(input logic [17:0] o, nw,
                                        input logic h, l);
    return {2'h0, h ? nw[15:8] : o[15:8], l ? nw[7:0] : o[7:0]};
  endfunction
  task automatic xfer(input dpc_op_t op, input logic t, h, l,
                      input logic [15:0] ad, input logic [17:0] d);
    @(posedge clk_in);
    req <= '{op, t, h, l, ad, d};
    vld <= 1;
    do @(posedge clk_in); while (rdy !== 1'b1);
    vld <= 0;
    for (int i = 0; i < 300 && rv !== 1'b1; i++) @(posedge clk_in);
    chk(18'(rv), 18'h1);
    repeat (2) @(posedge clk_in);
  endtask
  initial begin
    logic [15:0] ad;
    logic [17:0] d, e;
    void'($urandom(32'ha203));
    repeat (20) @(posedge clk_in);
    rst_in <= 0;
    for (int n = 0; n < 6; n++) begin
      ad = n == 0 ? 16'h0 : n == 5 ? 16'h7ffd : 16'($urandom_range(32'h7ffd));
      d = 18'($urandom) & 18'hffff;
      e = 18'($urandom) & 18'hffff;
      xfer(DPC_OP_WRITE, 0, 1, 1, ad, d);
      chk(18'(rsp.busy_seen), 18'h0);
      xfer(DPC_OP_WRITE, 0, n[0], !n[0], ad, e);
      xfer(DPC_OP_READ, 0, 1, 1, ad, 18'h0);
      chk(18'(rsp.data[15:0]), merge(d, e, n[0], !n[0]));
    end
    dev_u.mail();
    repeat (8) @(posedge clk_in);
    chk(18'(irq), 18'h1);
    xfer(DPC_OP_WRITE, 0, 1, 1, 16'h7fff, 18'h00a5);
    chk(18'(dev_u.oint), 18'h1);
    xfer(DPC_OP_READ, 0, 1, 1, 16'h7fff, 18'h0);
    chk(18'(rsp.data[15:0]), 18'h00a5);
    chk(18'(irq), 18'h1);
    xfer(DPC_OP_READ, 0, 1, 1, 16'h7ffe, 18'h0);
    repeat (4) @(posedge clk_in);
    chk(18'(irq), 18'h0);
    dev_u.busy(0);
    fork
      xfer(DPC_OP_WRITE, 0, 1, 1, 16'h0010, 18'h1234);
      begin
        repeat (30) @(posedge clk_in);
        dev_u.busy(1);
      end
    join
    chk(18'(rsp.busy_seen), 18'h1);
    xfer(DPC_OP_READ, 0, 1, 1, 16'h0010, 18'h0);
    chk(18'(rsp.data[15:0]), 18'h1234);
    // read raced by a remote write takes the flow-through path
    dev_u.busy(0);
    fork
      xfer(DPC_OP_READ, 0, 1, 1, 16'h0010, 18'h0);
      begin
        repeat (20) @(posedge clk_in);
        dev_u.busy(1);
      end
    join
    chk(18'(rsp.busy_seen), 18'h1);
    chk(18'(rsp.data[15:0]), 18'h1234);
    xfer(DPC_OP_WRITE, 1, 1, 1, 16'h0003, 18'h0);
    xfer(DPC_OP_READ, 1, 1, 1, 16'hfff3, 18'h0);
    chk(18'(rsp.token_won), 18'h1);
    chk(18'(rsp.data[15:0]), 18'h0);
    dev_u.grab(5);
    xfer(DPC_OP_WRITE, 1, 1, 1, 16'h0005, 18'h0);
    xfer(DPC_OP_READ, 1, 1, 1, 16'h0005, 18'h0);
    chk(18'(rsp.token_won), 18'h0);
    chk(18'(rsp.data[15:0]), 18'hffff);
    dev_u.drop(5);
    xfer(DPC_OP_READ, 1, 1, 1, 16'h0005, 18'h0);
    chk(18'(rsp.data[15:0]), 18'h0);
    chk(18'(rsp.token_won), 18'h1);
    xfer(DPC_OP_WRITE, 1, 1, 1, 16'h0003, 18'h1);
    xfer(DPC_OP_READ, 1, 1, 1, 16'h0003, 18'h0);
    chk(18'(rsp.data[15:0]), 18'hffff);
    report_and_stop();
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
